// File: dmac_pkg.sv
// Shared constants and types for the multiply-accumulate slice
`default_nettype none
package dmac_pkg;
	localparam int OPW = 18;
	localparam int PRW = 36;
	localparam int ACW = 54;

	// Slice configurations
	typedef enum logic [2:0] {
		single_product_accumulate,
		dual_product_accumulate,
		dual_product_combine,
		two_slice_product_sum,
		multiplier_bypass_add
	} dmac_mode_t;

	// Rounding methods
	typedef enum logic [2:0] {
		round_toward_zero,
		round_away_infinity,
		round_dynamic,
		round_random,
		round_convergent
	} dmac_round_t;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STAGE   = 8'h04;
	localparam logic [7:0] ADDR_PAT_LO  = 8'h08;
	localparam logic [7:0] ADDR_PAT_HI  = 8'h0c;
	localparam logic [7:0] ADDR_MASK_LO = 8'h10;
	localparam logic [7:0] ADDR_MASK_HI = 8'h14;
	localparam logic [7:0] ADDR_RES_LO  = 8'h18;
	localparam logic [7:0] ADDR_RES_HI  = 8'h1c;
	localparam logic [7:0] ADDR_FLAGS   = 8'h20;

	// Control register fields
	localparam int MODE_LSB  = 0;
	localparam int RND_LSB   = 3;
	localparam int RBITS_LSB = 6;
	localparam int IN_EN     = 12;
	localparam int PIPE_EN   = 13;
	localparam int OUT_EN    = 14;
	localparam int SERIAL    = 15;
	localparam int ASYNC_RST = 16;
	localparam int DYN_SUB   = 17;
	localparam int STAT_SUB  = 18;

	// Stage select fields, six bits per stage
	localparam int STG_W   = 6;
	localparam int CLK_OFS = 0;
	localparam int CE_OFS  = 2;
	localparam int RST_OFS = 4;

	localparam logic [31:0] CTRL_RST  = 32'h0000_4000;
	localparam logic [31:0] STAGE_RST = 32'h0000_0000;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;
endpackage : dmac_pkg
`default_nettype wire

// File: dmac_slice.sv
// Multiply-accumulate slice with AXI4-Lite configuration
`timescale 1ns/1ns
`default_nettype none
module dmac_slice (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              clock_source_0,
	input  wire logic              clock_source_1,
	input  wire logic              clock_source_2,
	input  wire logic              clock_source_3,
	input  wire logic [3:0]        stage_ce,
	input  wire logic [3:0]        stage_rst,
	input  wire logic [17:0]       operand_a_lo,
	input  wire logic [17:0]       operand_a_hi,
	input  wire logic [17:0]       operand_b_lo,
	input  wire logic [17:0]       operand_b_hi,
	input  wire logic [17:0]       shift_in_a,
	input  wire logic [17:0]       shift_in_b,
	input  wire logic [53:0]       addend_c,
	input  wire logic [53:0]       cascade_in,
	input  wire logic              subtract_sel,
	input  wire logic              acc_load,
	input  wire logic              round_dyn_up,
	output logic [17:0]            shift_out_a,
	output logic [17:0]            shift_out_b,
	output logic [53:0]            result,
	output logic [53:0]            cascade_out,
	output logic                   zero_match_flag,
	output logic                   masked_zero_flag,
	output logic                   masked_ones_flag,
	output logic                   pattern_match_flag,
	output logic                   inverse_pattern_flag,
	output logic                   acc_over_flag,
	output logic                   acc_under_flag,
	output logic                   acc_either_limit_flag
);
	import dmac_pkg::*;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] stage;
		logic [53:0] pat;
		logic [53:0] mask;
		logic [17:0] ra_lo;
		logic [17:0] ra_hi;
		logic [17:0] rb_lo;
		logic [17:0] rb_hi;
		logic        r_sub;
		logic        r_load;
		logic [53:0] r_c;
		logic [35:0] pa;
		logic [35:0] pb;
		logic        p_sub;
		logic        p_load;
		logic [53:0] p_c;
		logic [53:0] acc;
		logic [7:0]  flags;
		logic [15:0] lfsr;
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dmac_st_t;

	localparam dmac_st_t ST_RST = '{ctrl: CTRL_RST, stage: STAGE_RST, lfsr: LFSR_SEED,
		default: '0};

	dmac_st_t          s;
	dmac_st_t          next_s;
	dmac_mode_t        mode;
	logic              acc_mode;
	logic [3:0]        csrc;
	logic [2:0]        tick;
	logic [2:0]        rhit;
	logic [17:0]       a_lo_i;
	logic [17:0]       a_hi_i;
	logic [17:0]       b_lo_i;
	logic [17:0]       b_hi_i;
	logic              sub_in;
	logic              load_in;
	logic [53:0]       c_in;
	logic signed [35:0] pa_c;
	logic signed [35:0] pb_c;
	logic [35:0]       pa_i;
	logic [35:0]       pb_i;
	logic              sub_eff;
	logic              load_i;
	logic [54:0]       pa_x;
	logic [54:0]       pb_x;
	logic [54:0]       c_x;
	logic [54:0]       cin_x;
	logic [54:0]       base_x;
	logic [54:0]       prod_x;
	logic [54:0]       comb_x;
	logic [54:0]       alu;
	logic [53:0]       res;
	logic [7:0]        flg;
	logic              out_upd;

	// Byte-lane merge for register writes
	function automatic logic [31:0] wr32(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				v[8*i +: 8] = d[8*i +: 8];
			end
		end
		return v;
	endfunction : wr32

	// Readback word, bit 32 set when the address is mapped
	function automatic logic [32:0] rd33(input logic [7:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		unique case (a)
			ADDR_CTRL:    r[31:0] = s.ctrl;
			ADDR_STAGE:   r[31:0] = s.stage;
			ADDR_PAT_LO:  r[31:0] = s.pat[31:0];
			ADDR_PAT_HI:  r[21:0] = s.pat[53:32];
			ADDR_MASK_LO: r[31:0] = s.mask[31:0];
			ADDR_MASK_HI: r[21:0] = s.mask[53:32];
			ADDR_RES_LO:  r[31:0] = s.acc[31:0];
			ADDR_RES_HI:  r[21:0] = s.acc[53:32];
			ADDR_FLAGS:   r[7:0] = s.flags;
			default:      r[32] = 1'b0;
		endcase
		return r;
	endfunction : rd33

	// Round by adding a method-dependent constant and clearing the low n bits
	function automatic logic [53:0] rnd54(input logic [53:0] v, input logic [2:0] m,
		input logic [5:0] n, input logic [15:0] rv, input logic up);
		logic [53:0] half;
		logic [53:0] low;
		logic [53:0] c;
		logic [53:0] sh;
		half = (n == 6'h0) ? 54'h0 : (54'h1 << (n - 6'h1));
		low = (54'h1 << n) - 54'h1;
		sh = v >> n;
		unique case (m)
			round_toward_zero:   c = v[53] ? low : 54'h0;
			round_away_infinity: c = v[53] ? half - 54'h1 : half;
			round_dynamic:       c = up ? half : half - 54'h1;
			round_random:        c = {38'h0, rv} & low;
			round_convergent:    c = half - 54'h1 + {53'h0, sh[0]};
			default:             c = 54'h0;
		endcase
		return (n == 6'h0) ? v : ((v + c) & ~low);
	endfunction : rnd54

	// Per-stage clock source, enable and reset selection; stage 0 input, 1 pipe, 2 output
	assign csrc = {clock_source_3, clock_source_2, clock_source_1, clock_source_0};
	for (genvar g = 0; g < 3; g++) begin : g_stage
		logic [1:0] ck_sel;
		logic [1:0] ce_sel;
		logic [1:0] rs_sel;
		assign ck_sel = s.stage[g*STG_W + CLK_OFS +: 2];
		assign ce_sel = s.stage[g*STG_W + CE_OFS +: 2];
		assign rs_sel = s.stage[g*STG_W + RST_OFS +: 2];
		assign tick[g] = csrc[ck_sel] & stage_ce[ce_sel];
		// Async option resets without waiting for the stage clock; sync needs its clock source but not its enable
		assign rhit[g] = stage_rst[rs_sel] & (s.ctrl[ASYNC_RST] | csrc[ck_sel]);
	end

	assign mode = dmac_mode_t'(s.ctrl[MODE_LSB +: 3]);
	assign acc_mode = (mode == single_product_accumulate) || (mode == dual_product_accumulate);

	// Optional input stage: a disabled stage passes the pins straight through
	assign a_lo_i  = s.ctrl[IN_EN] ? s.ra_lo : operand_a_lo;
	assign a_hi_i  = s.ctrl[IN_EN] ? s.ra_hi : operand_a_hi;
	assign b_lo_i  = s.ctrl[IN_EN] ? s.rb_lo : operand_b_lo;
	assign b_hi_i  = s.ctrl[IN_EN] ? s.rb_hi : operand_b_hi;
	assign sub_in  = s.ctrl[IN_EN] ? s.r_sub : subtract_sel;
	assign load_in = s.ctrl[IN_EN] ? s.r_load : acc_load;
	assign c_in    = s.ctrl[IN_EN] ? s.r_c : addend_c;

	assign pa_c = $signed(a_lo_i) * $signed(a_hi_i);
	assign pb_c = $signed(b_lo_i) * $signed(b_hi_i);

	// Optional pipeline stage
	assign pa_i   = s.ctrl[PIPE_EN] ? s.pa : pa_c;
	assign pb_i   = s.ctrl[PIPE_EN] ? s.pb : pb_c;
	assign load_i = s.ctrl[PIPE_EN] ? s.p_load : load_in;
	assign sub_eff = s.ctrl[DYN_SUB] ? (s.ctrl[PIPE_EN] ? s.p_sub : sub_in)
		: s.ctrl[STAT_SUB];

	assign pa_x  = {{19{pa_i[35]}}, pa_i};
	assign pb_x  = {{19{pb_i[35]}}, pb_i};
	assign c_x   = s.ctrl[PIPE_EN] ? {s.p_c[53], s.p_c} : {c_in[53], c_in};
	assign cin_x = {cascade_in[53], cascade_in};

	// Loading the total replaces the feedback with the start value
	assign base_x = load_i ? c_x : {s.acc[53], s.acc};
	assign prod_x = (mode == single_product_accumulate) ? pa_x
		: pa_x + pb_x;
	assign comb_x = sub_eff ? pa_x - pb_x : pa_x + pb_x;

	// ALU: accumulate, combine, cascade sum or multiplier bypass
	assign alu = acc_mode ? (sub_eff ? base_x - prod_x : base_x + prod_x)
		: (mode == two_slice_product_sum) ? comb_x + cin_x
		: (mode == multiplier_bypass_add) ? (sub_eff ? c_x - cin_x : c_x + cin_x)
		: comb_x;

	// Rounding is skipped while accumulating so the total stays exact
	assign res = acc_mode ? alu[53:0]
		: rnd54(alu[53:0], s.ctrl[RND_LSB +: 3], s.ctrl[RBITS_LSB +: 6], s.lfsr, round_dyn_up);

	// Pattern flags come from the value that lands in the output register; limit flags from the top two bits of the 55-bit ALU sum
	assign flg[0] = (res == 54'h0);
	assign flg[1] = ((res & ~s.mask) == 54'h0);
	assign flg[2] = ((res | s.mask) == {54{1'b1}});
	assign flg[3] = (((res ^ s.pat) & ~s.mask) == 54'h0);
	assign flg[4] = (((res ^ ~s.pat) & ~s.mask) == 54'h0);
	assign flg[5] = acc_mode & ~alu[54] & alu[53];
	assign flg[6] = acc_mode & alu[54] & ~alu[53];
	assign flg[7] = flg[5] | flg[6];

	// Output register is forced in accumulate modes; otherwise an off stage follows each cycle
	assign out_upd = (acc_mode || s.ctrl[OUT_EN]) ? tick[2] : 1'b1;

	// Next-state logic
	always_comb begin
		logic [32:0] rw;
		logic [31:0] w32;
		next_s = s;
		rw = rd33(s.awaddr);
		w32 = wr32(rw[31:0], s.wdata, s.wstrb);
		next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};

		// Input registers: parallel load or shift from the previous slice
		if (rhit[0]) begin
			next_s.ra_lo = '0;
			next_s.ra_hi = '0;
			next_s.rb_lo = '0;
			next_s.rb_hi = '0;
			next_s.r_sub = 1'b0;
			next_s.r_load = 1'b0;
			next_s.r_c = '0;
		end else if (tick[0]) begin
			next_s.ra_lo = s.ctrl[SERIAL] ? shift_in_a : operand_a_lo;
			next_s.rb_lo = s.ctrl[SERIAL] ? shift_in_b : operand_b_lo;
			next_s.ra_hi = operand_a_hi;
			next_s.rb_hi = operand_b_hi;
			next_s.r_sub = subtract_sel;
			next_s.r_load = acc_load;
			next_s.r_c = addend_c;
		end

		// Pipeline registers
		if (rhit[1]) begin
			next_s.pa = '0;
			next_s.pb = '0;
			next_s.p_sub = 1'b0;
			next_s.p_load = 1'b0;
			next_s.p_c = '0;
		end else if (tick[1]) begin
			next_s.pa = pa_c;
			next_s.pb = pb_c;
			next_s.p_sub = sub_in;
			next_s.p_load = load_in;
			next_s.p_c = c_in;
		end

		// Output register and flags move together
		if (rhit[2]) begin
			next_s.acc = '0;
			// Flags must still describe the cleared total, or they would lie about it
			next_s.flags = {3'b000, ((~s.pat & ~s.mask) == 54'h0), ((s.pat & ~s.mask) == 54'h0),
				(s.mask == {54{1'b1}}), 2'b11};
		end else if (out_upd) begin
			next_s.acc = res;
			next_s.flags = flg;
		end

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OK;
			unique case (s.awaddr)
				ADDR_CTRL:    next_s.ctrl = w32;
				ADDR_STAGE:   next_s.stage = w32;
				ADDR_PAT_LO:  next_s.pat[31:0] = w32;
				ADDR_PAT_HI:  next_s.pat[53:32] = w32[21:0];
				ADDR_MASK_LO: next_s.mask[31:0] = w32;
				ADDR_MASK_HI: next_s.mask[53:32] = w32[21:0];
				default:      next_s.bresp = RESP_ERR;
			endcase
		end else if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;

		// Read channel: one read in flight
		if (s_axi_arvalid && s.arready) begin
			rw = rd33(s_axi_araddr);
			next_s.rvalid = 1'b1;
			next_s.rdata = rw[31:0];
			next_s.rresp = rw[32] ? RESP_OK : RESP_ERR;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		next_s.arready = !next_s.rvalid;
	end

	// State register; global reset is synchronous
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= ST_RST;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign shift_out_a   = s.ra_lo;
	assign shift_out_b   = s.rb_lo;
	assign result        = s.acc;
	assign cascade_out   = s.acc;
	assign zero_match_flag       = s.flags[0];
	assign masked_zero_flag      = s.flags[1];
	assign masked_ones_flag      = s.flags[2];
	assign pattern_match_flag    = s.flags[3];
	assign inverse_pattern_flag  = s.flags[4];
	assign acc_over_flag         = s.flags[5];
	assign acc_under_flag        = s.flags[6];
	assign acc_either_limit_flag = s.flags[7];
endmodule : dmac_slice
`default_nettype wire

// File: dmac_fabric_src.sv
// Fabric-side model: clock-source ticks and clock enables for the slice stages
`timescale 1ns/1ns
`default_nettype none
module dmac_fabric_src (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	output logic            clock_source_0,
	output logic            clock_source_1,
	output logic            clock_source_2,
	output logic            clock_source_3,
	output logic [3:0]      stage_ce
);
	logic [1:0] tick_cnt;

	// Free-running divider that paces the slower tick sources
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tick_cnt <= 2'h0;
		end else begin
			tick_cnt <= tick_cnt + 2'h1;
		end
	end

	// Four distinct sources so a wrong stage selection shows at the result
	assign clock_source_0 = 1'b1;
	assign clock_source_1 = tick_cnt[0];
	assign clock_source_2 = (tick_cnt == 2'h3);
	assign clock_source_3 = 1'b0; // Parked, lets a stage be frozen on purpose
	assign stage_ce       = 4'h7; // Line 3 held shut so a stage can pick a closed enable
endmodule : dmac_fabric_src
`default_nettype wire

// File: dmac_slice_monitor.sv
// Port-level checker for the multiply-accumulate slice
`timescale 1ns/1ns
`default_nettype none
module dmac_slice_monitor
	import dmac_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [53:0] result,
	input wire logic [53:0] cascade_out,
	input wire logic        zero_match_flag,
	input wire logic        acc_over_flag,
	input wire logic        acc_under_flag,
	input wire logic        acc_either_limit_flag
);
	// Single clock domain, so one clocking and one disable for all
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Bus handshake ordering
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before accepted");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before accepted");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted during response");
	err_data_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_ERR |-> s_axi_rdata == '0)
		else $error("error read carries data");
	// Flag relations and the cascade copy against the registered result
	either_flag_a: assert property (acc_either_limit_flag == (acc_over_flag || acc_under_flag))
		else $error("combined limit flag wrong");
	limit_excl_a: assert property (!(acc_over_flag && acc_under_flag))
		else $error("overflow and underflow together");
	zero_flag_a: assert property ($changed(result) |-> zero_match_flag == (result == '0))
		else $error("zero flag disagrees with result");
	cascade_same_a: assert property (cascade_out == result)
		else $error("cascade output differs from result");
endmodule : dmac_slice_monitor

bind dmac_slice dmac_slice_monitor u_mon (.*);
`default_nettype wire

// File: dsp_multiply_accumulate_slice_tb_top.sv
// Self-checking testbench for the multiply-accumulate slice
`timescale 1ns/1ns
`default_nettype none
module dsp_multiply_accumulate_slice_tb_top;
	import dmac_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf, stage_ce, stage_rst = 4'h0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        clock_source_0, clock_source_1, clock_source_2, clock_source_3;
	logic [17:0] operand_a_lo = '0, operand_a_hi = '0, operand_b_lo = '0, operand_b_hi = '0;
	logic [17:0] shift_in_a = '0, shift_in_b = '0, shift_out_a, shift_out_b;
	logic [53:0] addend_c = '0, cascade_in = '0, result, cascade_out;
	logic        subtract_sel = 0, acc_load = 0, round_dyn_up = 0;
	logic        zero_match_flag, masked_zero_flag, masked_ones_flag, pattern_match_flag;
	logic        inverse_pattern_flag, acc_over_flag, acc_under_flag, acc_either_limit_flag;
	int          n_fail = 0, checks = 0;

	dmac_slice DUT (.*);
	dmac_fabric_src u_src (.*);

	// 10 MHz system clock
	always #50 clk_sys = ~clk_sys;

	task automatic summarize();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	// One bus transfer; slow holds the response ready low for a cycle first
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic sl, output logic [31:0] q, output logic [1:0] r);
		int   n;
		logic pa, pw, dn;
		pa = 1;
		pw = wr;
		dn = 0;
		n = 0;
		@(posedge clk_sys);
		if (wr) begin
			{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} <= {a, 1'b1, d, 1'b1, !sl};
		end else begin
			{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, !sl};
		end
		while (!dn && n < 60) begin
			@(posedge clk_sys);
			n++;
			if (pa && (wr ? s_axi_awready : s_axi_arready)) begin
				pa = 0;
				{s_axi_awvalid, s_axi_arvalid} <= 2'b00;
			end
			if (pw && s_axi_wready) begin
				pw = 0;
				s_axi_wvalid <= 1'b0;
			end
			if (wr ? (s_axi_bvalid && s_axi_bready) : (s_axi_rvalid && s_axi_rready)) begin
				dn = 1;
				q = s_axi_rdata;
				r = wr ? s_axi_bresp : s_axi_rresp;
				{s_axi_bready, s_axi_rready} <= 2'b00;
			end else if (wr ? s_axi_bvalid : s_axi_rvalid) begin
				{s_axi_bready, s_axi_rready} <= {wr, !wr};
			end
		end
		if (!dn) begin
			n_fail++;
			summarize();
		end
	endtask : axi

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e, input logic sl);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'b1, a, d, sl, q, r);
		cmp("bresp", e, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e, input logic sl);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'b0, a, '0, sl, q, r);
		cmp("rresp", e, r);
		cmp("rdata", d, q);
	endtask : rd

	// Present one set of operands for a single cycle, then sample after lat edges
	task automatic run(input logic [17:0] al, ah, bl, bh, input logic ld, sb,
		input logic [53:0] c, cs, input int lat);
		@(posedge clk_sys);
		{operand_a_lo, operand_a_hi, operand_b_lo, operand_b_hi, acc_load, subtract_sel,
			addend_c, cascade_in} <= {al, ah, bl, bh, ld, sb, c, cs};
		@(posedge clk_sys);
		{operand_a_lo, operand_a_hi, operand_b_lo, operand_b_hi, acc_load, subtract_sel,
			addend_c, cascade_in} <= '0;
		repeat (lat) @(posedge clk_sys);
	endtask : run

	task automatic t_regs();
		rd(ADDR_CTRL, CTRL_RST, RESP_OK, 1'b0);
		rd(ADDR_STAGE, STAGE_RST, RESP_OK, 1'b1);
		rd(8'h40, '0, RESP_ERR, 1'b0);
		wr(ADDR_RES_LO, 32'h0000_0001, RESP_ERR, 1'b1);
		wr(ADDR_PAT_HI, 32'hffff_ffff, RESP_OK, 1'b1);
		rd(ADDR_PAT_HI, 32'h003f_ffff, RESP_OK, 1'b0);
		wr(ADDR_PAT_HI, '0, RESP_OK, 1'b0);
	endtask : t_regs

	task automatic t_acc();
		run(3, 4, 0, 0, 1, 0, 100, 0, 1);
		cmp("result", 112, result);
		run(3, 4, 0, 0, 0, 0, 0, 0, 1);
		cmp("result", 124, result);
		rd(ADDR_RES_LO, 124, RESP_OK, 1'b0);
		wr(ADDR_CTRL, 32'h0002_4000, RESP_OK, 1'b0);
		run(3, 4, 0, 0, 0, 1, 0, 0, 1);
		cmp("result", 112, result);
		run(3, 4, 0, 0, 0, 0, 0, 0, 1);
		cmp("result", 124, result);
		wr(ADDR_CTRL, CTRL_RST, RESP_OK, 1'b0);
	endtask : t_acc

	task automatic t_limit();
		run(1, 1, 0, 0, 1, 0, 54'h1f_ffff_ffff_ffff, 0, 1);
		cmp("result", 54'h20_0000_0000_0000, result);
		cmp("limits", 3'b101, {acc_over_flag, acc_under_flag, acc_either_limit_flag});
		rd(ADDR_RES_HI, 32'h0020_0000, RESP_OK, 1'b0);
		run(1, 18'h3_ffff, 0, 0, 1, 0, 54'h20_0000_0000_0000, 0, 1);
		cmp("result", 54'h1f_ffff_ffff_ffff, result);
		cmp("limits", 3'b011, {acc_over_flag, acc_under_flag, acc_either_limit_flag});
	endtask : t_limit

	task automatic t_flags();
		logic [53:0] v [5] = '{54'h1234, 54'hedcb, 54'hffff, 54'h1_0000, 54'h0};
		logic [4:0]  f [5] = '{5'b00010, 5'b00001, 5'b00100, 5'b01000, 5'b11000};
		wr(ADDR_PAT_LO, 32'h0000_1234, RESP_OK, 1'b0);
		wr(ADDR_MASK_LO, 32'hffff_0000, RESP_OK, 1'b0);
		wr(ADDR_MASK_HI, 32'h003f_ffff, RESP_OK, 1'b0);
		for (int i = 0; i < 5; i++) begin
			run(0, 0, 0, 0, 1, 0, v[i], 0, 1);
			cmp("flags", f[i], {zero_match_flag, masked_zero_flag, masked_ones_flag,
				pattern_match_flag, inverse_pattern_flag});
		end
		rd(ADDR_FLAGS, 32'h0000_0003, RESP_OK, 1'b0);
	endtask : t_flags

	task automatic pulse_rst(input logic [53:0] e);
		@(posedge clk_sys);
		stage_rst <= 4'h1;
		@(posedge clk_sys);
		stage_rst <= 4'h0;
		@(posedge clk_sys);
		cmp("result", e, result);
	endtask : pulse_rst

	task automatic t_stage();
		run(0, 0, 0, 0, 1, 0, 77, 0, 1);
		wr(ADDR_STAGE, 32'h0000_c000, RESP_OK, 1'b0);
		run(3, 4, 0, 0, 0, 0, 0, 0, 1);
		cmp("result", 77, result);
		wr(ADDR_STAGE, 32'h0001_0000, RESP_OK, 1'b0);
		pulse_rst(77);
		wr(ADDR_STAGE, 32'h0000_3000, RESP_OK, 1'b0);
		run(3, 4, 0, 0, 0, 0, 0, 0, 1);
		cmp("result", 77, result);
		pulse_rst(77);
		wr(ADDR_CTRL, 32'h0001_4000, RESP_OK, 1'b0);
		pulse_rst(0);
		wr(ADDR_STAGE, STAGE_RST, RESP_OK, 1'b0);
		wr(ADDR_CTRL, CTRL_RST, RESP_OK, 1'b0);
		run(0, 0, 0, 0, 1, 0, 77, 0, 1);
		pulse_rst(0);
	endtask : t_stage

	task automatic t_modes();
		wr(ADDR_CTRL, 32'h0000_5001, RESP_OK, 1'b0);
		run(3, 4, 5, 6, 1, 0, 10, 0, 2);
		cmp("result", 52, result);
		run(3, 4, 5, 6, 0, 0, 0, 0, 2);
		cmp("result", 94, result);
		wr(ADDR_CTRL, 32'h0004_4002, RESP_OK, 1'b0);
		run(7, 8, 2, 3, 0, 0, 0, 0, 1);
		cmp("result", 50, result);
		run(2, 3, 7, 8, 0, 0, 0, 0, 1);
		cmp("result", 54'h3f_ffff_ffff_ffce, result);
		wr(ADDR_CTRL, 32'h0000_4003, RESP_OK, 1'b0);
		run(3, 4, 5, 6, 0, 0, 0, 100, 1);
		cmp("result", 142, result);
		wr(ADDR_CTRL, 32'h0000_4004, RESP_OK, 1'b0);
		run(0, 0, 0, 0, 0, 0, 1000, 234, 1);
		cmp("result", 1234, result);
		run(0, 0, 0, 0, 0, 0, 54'h3f_ffff_ffff_ffff, 1, 1);
		cmp("result", 0, result);
	endtask : t_modes

	// Rounding in combine mode: add a constant, then clear the four low bits
	task automatic t_round();
		wr(ADDR_CTRL, 32'h0000_4102, RESP_OK, 1'b0);
		run(37, 1, 0, 0, 0, 0, 0, 0, 1);
		cmp("rounded", 32, result);
		run(37, 18'h3_ffff, 0, 0, 0, 0, 0, 0, 1);
		cmp("rounded", 54'h3f_ffff_ffff_ffe0, result);
		wr(ADDR_CTRL, 32'h0000_410a, RESP_OK, 1'b0);
		run(5, 8, 0, 0, 0, 0, 0, 0, 1);
		cmp("rounded", 48, result);
		wr(ADDR_CTRL, 32'h0000_4122, RESP_OK, 1'b0);
		run(5, 8, 0, 0, 0, 0, 0, 0, 1);
		cmp("rounded", 32, result);
		run(7, 8, 0, 0, 0, 0, 0, 0, 1);
		cmp("rounded", 64, result);
		wr(ADDR_CTRL, 32'h0000_411a, RESP_OK, 1'b0);
		run(4, 8, 0, 0, 0, 0, 0, 0, 1);
		cmp("rounded", 32, result);
		wr(ADDR_CTRL, 32'h0000_4112, RESP_OK, 1'b0);
		round_dyn_up <= 1'b1;
		run(5, 8, 0, 0, 0, 0, 0, 0, 1);
		cmp("rounded", 48, result);
		round_dyn_up <= 1'b0;
		run(5, 8, 0, 0, 0, 0, 0, 0, 1);
		cmp("rounded", 32, result);
		wr(ADDR_CTRL, CTRL_RST, RESP_OK, 1'b0);
	endtask : t_round

	// Serial load takes a_lo and b_lo from the shift chain, not from the pins
	task automatic t_serial();
		wr(ADDR_CTRL, 32'h0000_d000, RESP_OK, 1'b0);
		{shift_in_a, shift_in_b} <= {18'h0_0005, 18'h0_0006};
		run(100, 3, 200, 0, 1, 0, 0, 0, 2);
		cmp("result", 15, result);
		cmp("shift_out", {18'h0_0005, 18'h0_0006}, {shift_out_a, shift_out_b});
		{shift_in_a, shift_in_b} <= '0;
		wr(ADDR_CTRL, CTRL_RST, RESP_OK, 1'b0);
	endtask : t_serial

	// Main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_acc();
		t_limit();
		t_flags();
		t_stage();
		t_modes();
		t_round();
		t_serial();
		summarize();
	end
endmodule : dsp_multiply_accumulate_slice_tb_top
`default_nettype wire
